// ---- include/debug_regs_regs.vh ----
/*
  Constants for the background debug register block: global addresses,
  field positions, reset values and access command codes.
  Assumes inclusion by bare name from design files under hdl/.
*/
// Summary of operation
// - entering debug copies live condition code
// - special single-chip reset leaves hold at 0xD8
// - other reset modes read hold as zero
// - host may write hold register
// - firmware may use hold as scratch
// - page bit 7 enables paged debug access
// - paged access is refused in the cycle after a hardware command
// - page bits 3..0 select program page
// - page register decoded at 0x3_FF08
// - family byte read-only at 0x3_FF0F
// - serial host commands, hardware or firmware
// - page access only via debug, unsecured
`ifndef DEBUG_REGS_REGS_VH
`define DEBUG_REGS_REGS_VH

`define ADDR_W             18
`define ADDR_PROGRAM_PAGE  18'h3FF08
`define ADDR_FAMILY_IDENTIFIER     18'h3FF0F
`define ADDR_COND_HOLD     18'h3FF06
`define PAGE_ENABLE_BIT    7
`define PAGE_INDEX_HI      3
`define PAGE_INDEX_LO      0
`define PAGE_WRITE_MASK    8'h8F
`define HOLD_RESET_SPECIAL 8'hD8
`define HOLD_RESET_OTHER   8'h00
`define PAGE_RESET         8'h00
`define FAMILY_IDENTIFIER_VALUE    8'h5A  // arbitrary value, names no part
`define CMD_CLASS_HW       1'b0
`define CMD_CLASS_FW       1'b1

`endif

// ---- hdl/debug_registers.v ----
/*
  Register part of the background debug unit: condition code holding
  register, program page register and family identification byte.
  Assumes the serial command decoder supplies one-cycle access strobes
  with address, data and command class, all synchronous to core_clk.
  Assumes the mode strap is stable around the release of arst_n, and
  that debug_active and secured come from registered logic of the same
  clock domain. The paged access qualifier is registered, so the paging
  logic that uses it sees the command class of the previous cycle.
*/
`timescale 1ns/1ps
`default_nettype none

`include "debug_regs_regs.vh"

module debug_registers (
  input  wire                 core_clk,
  input  wire                 arst_n,
  input  wire                 special_single_chip,
  input  wire                 secured,
  input  wire                 debug_active,
  input  wire [7:0]           condition_code_register,
  input  wire                 acc_rd,
  input  wire                 acc_wr,
  input  wire                 acc_fw,
  input  wire [`ADDR_W-1:0]   acc_addr,
  input  wire [7:0]           acc_wdata,
  output reg  [7:0]           acc_rdata,
  output reg                  acc_rvalid,
  output reg  [7:0]           debug_condition_hold,
  output reg                  page_access_enable,
  output reg  [3:0]           page_index_bits,
  output reg                  paged_access_allowed
);

  // arbitrary neutral identification value
  parameter [7:0] FAMILY_IDENTIFIER = `FAMILY_IDENTIFIER_VALUE;

  // edge detect and reset tracking
  reg        debug_active_q;
  reg        rst_seen_q;

  // stored contents and their next values
  reg  [7:0] page_q;
  reg  [7:0] page_d;
  reg  [7:0] hold_d;

  // read response next values
  reg  [7:0] rdata_d;
  reg        rvalid_d;

  // address decode
  reg        hit_hold;
  reg        hit_page;
  reg        hit_id;

  // qualified strobes
  wire       enter_debug;
  wire       access_ok;
  wire       wr_ok;
  wire       rd_ok;
  wire       fw_cmd;

  // compares a bus address against one register address
  function addr_match;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] target;
    begin
      addr_match = (addr == target);
    end
  endfunction

  // rising edge of debug activity
  assign enter_debug = debug_active & ~debug_active_q;

  assign access_ok   = debug_active & ~secured;
  assign wr_ok       = acc_wr & access_ok;
  assign rd_ok       = acc_rd & access_ok;

  assign fw_cmd      = (acc_fw == `CMD_CLASS_FW);

  // one decode per mapped register
  always @* begin
    // condition hold address
    hit_hold = addr_match(acc_addr, `ADDR_COND_HOLD);
    hit_page = addr_match(acc_addr, `ADDR_PROGRAM_PAGE);
    hit_id   = addr_match(acc_addr, `ADDR_FAMILY_IDENTIFIER);
  end

  // refused and unmapped reads return zero
  always @* begin
    rdata_d  = 8'h00;
    rvalid_d = rd_ok;
    if (rd_ok) begin
      if (hit_hold) begin
        rdata_d = debug_condition_hold;
      end else if (hit_page) begin
        rdata_d = page_q;
      end else if (hit_id) begin
        rdata_d = FAMILY_IDENTIFIER;
      end
    end
  end

  // entry capture beats a host write in the same cycle
  always @* begin
    hold_d = debug_condition_hold;
    if (!rst_seen_q) begin
      if (special_single_chip) begin
        hold_d = `HOLD_RESET_SPECIAL;
      end else begin
        hold_d = `HOLD_RESET_OTHER;
      end
    end else if (enter_debug) begin
      hold_d = condition_code_register;
    end else if (wr_ok && hit_hold) begin
      hold_d = acc_wdata;
    end
  end

  // bits 6..4 are not implemented and read as zero
  always @* begin
    page_d = page_q;
    if (wr_ok && hit_page) begin
      page_d = acc_wdata & `PAGE_WRITE_MASK;
    end
  end

  // delayed copy for entry detection
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      debug_active_q <= 1'b0;
    end else begin
      debug_active_q <= debug_active;
    end
  end

  // mode strap is taken on the first edge after reset release
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_seen_q <= 1'b0;
    end else begin
      rst_seen_q <= 1'b1;
    end
  end

  // holding register keeps its value until the strap load after reset, a capture or a write
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      debug_condition_hold <= `HOLD_RESET_OTHER;
    end else begin
      debug_condition_hold <= hold_d;
    end
  end

  // page register resets to a disabled window
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      page_q <= `PAGE_RESET;
    end else begin
      page_q <= page_d;
    end
  end

  // read answer stands for one cycle
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_rvalid <= 1'b0;
    end else begin
      acc_rvalid <= rvalid_d;
    end
  end

  // read data is zero unless a read was taken
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_rdata <= 8'h00;
    end else begin
      acc_rdata <= rdata_d;
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      page_access_enable <= 1'b0;
    end else begin
      page_access_enable <= page_q[`PAGE_ENABLE_BIT];
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      page_index_bits <= 4'h0;
    end else begin
      page_index_bits <= page_q[`PAGE_INDEX_HI:`PAGE_INDEX_LO];
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      paged_access_allowed <= 1'b0;
    end else begin
      paged_access_allowed <= page_q[`PAGE_ENABLE_BIT] & access_ok & fw_cmd;
    end
  end

endmodule

`default_nettype wire

// ---- dv/debug_host.sv ----
/* debug host model: one register command per call; needs core_clk */
`timescale 1ns/1ps
`default_nettype none
module debug_host(
  input  wire logic   core_clk,
  output logic        acc_rd, acc_wr, acc_fw,
  output logic [17:0] acc_addr,
  output logic [7:0]  acc_wdata);
  initial {acc_rd, acc_wr, acc_fw, acc_addr, acc_wdata} = '0;
  task op(input logic w, f, input logic [17:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {acc_rd, acc_wr, acc_fw, acc_addr, acc_wdata} = {!w, w, f, a, d};
    @(negedge core_clk);
    {acc_rd, acc_wr, acc_addr, acc_wdata} = {2'b00, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// ---- dv/debug_registers_assertions.sv ----
/* checker for the debug registers; bound to every instance */
`timescale 1ns/1ps
`default_nettype none
module dbg_chk(
  input wire logic core_clk, arst_n, secured, debug_active, acc_rd, acc_wr, acc_fw,
  input wire logic acc_rvalid, page_access_enable, paged_access_allowed,
  input wire logic [17:0] acc_addr,
  input wire logic [7:0] condition_code_register, acc_wdata, acc_rdata, debug_condition_hold,
  input wire logic [3:0] page_index_bits);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire ok = debug_active && !secured;
  sequence pg_wr; acc_wr && ok && acc_addr == 18'h3FF08; endsequence
  sequence hd_wr; acc_wr && ok && acc_addr == 18'h3FF06 && !$rose(debug_active); endsequence
  a_read_answer: assert property (acc_rd && ok |=> acc_rvalid) else $error("read lost");
  a_read_refused: assert property (acc_rd && !ok |=> !acc_rvalid) else $error("read leaked");
  a_family_value: assert property (acc_rd && ok && acc_addr == 18'h3FF0F |=>
    acc_rdata == 8'h5A) else $error("family byte wrong");
  a_entry_capture: assert property ($rose(debug_active) && $past(arst_n) |=>
    debug_condition_hold == $past(condition_code_register)) else $error("no capture");
  a_hold_write: assert property (hd_wr |=> debug_condition_hold == $past(acc_wdata))
    else $error("hold write lost");
  a_page_enable: assert property (pg_wr |-> ##2
    page_access_enable == $past(acc_wdata[7], 2)) else $error("page enable wrong");
  a_page_index: assert property (pg_wr |-> ##2
    page_index_bits == $past(acc_wdata[3:0], 2)) else $error("page index wrong");
  a_hw_unpaged: assert property (!$past(acc_fw) |-> !paged_access_allowed)
    else $error("paged on hw cmd");
endmodule
bind debug_registers dbg_chk u_chk(.*);
`default_nettype wire

// ---- dv/tb.sv ----
/* top bench for the debug registers; needs host model and checker */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 0, arst_n = 0, special_single_chip = 0, secured = 0, debug_active = 1;
  logic [7:0] condition_code_register = 8'h3C;
  wire logic acc_rd, acc_wr, acc_fw, acc_rvalid, page_access_enable, paged_access_allowed;
  wire logic [17:0] acc_addr;
  wire logic [7:0] acc_wdata, acc_rdata, debug_condition_hold;
  wire logic [3:0] page_index_bits;
  int failures = 0, n_compared = 0, cyc = 0;
  debug_host u_debug_host(.*);
  debug_registers u_debug_registers(.*);
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc > 500) begin failures++; test_done; end
  task chk(input logic [7:0] s, e);
    n_compared++;
    if (s !== e) begin failures++; $display("Error %0t: got %h exp %h", $time, s, e); end
  endtask
  task rd(input logic [17:0] a, input logic [7:0] e);
    u_debug_host.op(0, 0, a, 0);
    chk({7'h00, acc_rvalid}, 8'h01);
    chk(acc_rdata, e);
  endtask
  task boot(input logic m);
    special_single_chip = m;
    arst_n = 0;
    repeat (3) @(negedge core_clk);
    arst_n = 1;
    @(negedge core_clk);
  endtask
  task test_done;
    $display("failures %0d compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    boot(1); rd(18'h3FF06, 8'hD8);
    chk(debug_condition_hold, 8'hD8);
    boot(0); rd(18'h3FF06, 8'h00);
    u_debug_host.op(1, 0, 18'h3FF0F, 8'h00); rd(18'h3FF0F, 8'h5A);
    u_debug_host.op(1, 0, 18'h3FF08, 8'hFF); rd(18'h3FF08, 8'h8F);
    chk({page_access_enable, 3'h0, page_index_bits}, 8'h8F);
    chk({7'h00, paged_access_allowed}, 8'h00);
    u_debug_host.op(0, 1, 18'h3FF08, 8'h00);
    chk({7'h00, paged_access_allowed}, 8'h01);
    secured = 1;
    u_debug_host.op(0, 0, 18'h3FF08, 8'h00);
    chk({7'h00, acc_rvalid}, 8'h00);
    u_debug_host.op(1, 0, 18'h3FF08, 8'h00);
    secured = 0;
    rd(18'h3FF08, 8'h8F);
    u_debug_host.op(1, 1, 18'h3FF06, 8'h55); rd(18'h3FF06, 8'h55);
    debug_active = 0;
    @(negedge core_clk);
    debug_active = 1;
    rd(18'h3FF06, 8'h3C);
    rd(18'h3FF00, 8'h00);
    test_done;
  end
endmodule
`default_nettype wire
